// File: logic/uhe_pkg.sv
// Shared constants, register map and carrier types of the host register block
package uhe_pkg;

  // ---------------------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int RX_DEPTH = 8;
  localparam int CNT_W    = 4;
  localparam int ERR_W    = 3;
  localparam int ENTRY_W  = ERR_W + DATA_W;

  // ---------------------------------------------------------------------------
  // Host side offsets
  // ---------------------------------------------------------------------------
  localparam logic [2:0] HA_DATA = 3'h0;
  localparam logic [2:0] HA_IE   = 3'h1;
  localparam logic [2:0] HA_IIR  = 3'h2;
  localparam logic [2:0] HA_LCR  = 3'h3;
  localparam logic [2:0] HA_MCR  = 3'h4;
  localparam logic [2:0] HA_LSR  = 3'h5;
  localparam logic [2:0] HA_MSR  = 3'h6;

  // ---------------------------------------------------------------------------
  // Processor side offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CA_DATA  = 8'hF0;
  localparam logic [7:0] CA_IE    = 8'hF1;
  localparam logic [7:0] CA_LCR   = 8'hF3;
  localparam logic [7:0] CA_MCR   = 8'hF4;
  localparam logic [7:0] CA_LSR   = 8'hF5;
  localparam logic [7:0] CA_MSR   = 8'hF6;
  localparam logic [7:0] CA_TWEAK = 8'hE9;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int LCR_DAB   = 7;
  localparam int MCR_LOOP  = 4;
  localparam int MCR_OUT2  = 3;
  localparam int MCR_OUT1  = 2;
  localparam int MCR_RTS   = 1;
  localparam int MCR_DTR   = 0;
  localparam int TWEAK_OVW = 1;
  localparam int IE_RDA    = 0;
  localparam int IE_HOLDING_EMPTY_FLAG   = 1;
  localparam int IE_LS     = 2;
  localparam int IE_MS     = 3;
  localparam int LSR_TEMT  = 6;
  localparam int LSR_ERR_L = 2;
  localparam logic [1:0] MASTER_OUT2 = 2'b10;

  // ---------------------------------------------------------------------------
  // Identification codes and reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ID_LINE  = 3'b011;
  localparam logic [2:0] ID_TRIG  = 3'b010;
  localparam logic [2:0] ID_TOUT  = 3'b110;
  localparam logic [2:0] ID_HOLDING_EMPTY_FLAG  = 3'b001;
  localparam logic [2:0] ID_MODEM = 3'b000;
  localparam logic [7:0] IIR_RST  = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [2:0]       addr;
    logic [DATA_W-1:0] wdata;
  } uhe_host_req_t;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [7:0]       addr;
    logic [DATA_W-1:0] wdata;
  } uhe_cpu_req_t;

  typedef struct packed {
    logic [ERR_W-1:0]  err;   // Break, framing, parity
    logic [DATA_W-1:0] data;
  } uhe_rx_entry_t;

  // Receive trigger level from the two-bit select
  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'b00:   trig_level = 4'h1;
      2'b01:   trig_level = 4'h4;
      2'b10:   trig_level = 4'h8;
      default: trig_level = 4'hE;
    endcase
  endfunction

endpackage

// File: logic/uhe_fifo.sv
// Receive FIFO with overwrite of the newest entry and a flag summary
`timescale 1ns/1ps
module uhe_fifo
  import uhe_pkg::*;
#(
  parameter int WIDTH   = 11,
  parameter int DEPTH   = 8,
  parameter int FLAG_L  = 8,
  parameter int FLAG_W  = 3
)(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic             i_overwrite,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data,
  // Status
  output logic [$clog2(DEPTH+1)-1:0] o_count,
  output logic                  o_flag_any
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic             push;
  logic             pop;
  logic [PW-1:0]    last;

  assign o_ready = (cnt_q != CW'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign push    = i_valid && o_ready;
  assign pop     = i_ready && o_valid;
  assign last    = wr_q - PW'(1);
  assign o_data  = mem_q[rd_q];
  assign o_count = cnt_q;

  // Storage, with newest slot rewritten on overwrite
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_q[wr_q] <= i_data;
    else if (i_overwrite && o_valid)
      mem_q[last] <= i_data;
  end

  // Pointers and fill count
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + PW'(1);
      if (pop)
        rd_q <= rd_q + PW'(1);
      if (push && !pop)
        cnt_q <= cnt_q + CW'(1);
      else if (pop && !push)
        cnt_q <= cnt_q - CW'(1);
    end
  end

  // Any stored entry carrying a flag
  always_comb
  begin
    o_flag_any = 1'b0;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (CW'(i) < cnt_q)
        o_flag_any = o_flag_any |
          (|mem_q[PW'(rd_q + PW'(i))][FLAG_L +: FLAG_W]);
    end
  end

endmodule // uhe_fifo

// File: logic/uhe_prio.sv
// Interrupt source priority encoder for the identification field
`timescale 1ns/1ps
module uhe_prio
  import uhe_pkg::*;
(
  // Enabled pending sources
  input  wire logic       i_line,
  input  wire logic       i_trig,
  input  wire logic       i_tout,
  input  wire logic       i_holding_empty_flag,
  input  wire logic       i_modem,
  // Result
  output logic [2:0]      o_id,
  output logic            o_pend
);
  // Highest pending source wins
  always_comb
  begin
    o_pend = i_line | i_trig | i_tout | i_holding_empty_flag | i_modem;
    if (i_line)
      o_id = ID_LINE;
    else if (i_trig)
      o_id = ID_TRIG;
    else if (i_tout)
      o_id = ID_TOUT;
    else if (i_holding_empty_flag)
      o_id = ID_HOLDING_EMPTY_FLAG;
    else
      o_id = ID_MODEM;
  end

endmodule // uhe_prio

// File: logic/uhe_host_regs.sv
// Host-visible serial port emulation registers, host and processor ports
`timescale 1ns/1ps

module uhe_host_regs
  import uhe_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  // Host register port
  input  wire uhe_host_req_t i_host_req,
  output logic [DATA_W-1:0]  o_host_rdata,
  output logic               o_host_int,
  // Processor register port
  input  wire uhe_cpu_req_t  i_cpu_req,
  output logic [DATA_W-1:0]  o_cpu_rdata,
  output logic               o_tx_full,
  // Mode and timer status from neighbouring logic
  input  wire logic          i_fifo_mode,
  input  wire logic [1:0]    i_trig_sel,
  input  wire logic          i_rx_delay_en,
  input  wire logic          i_rx_delay_done,
  input  wire logic          i_tx_delay_en,
  input  wire logic          i_tx_delay_done,
  input  wire logic          i_rx_timeout,
  input  wire logic          i_double_buf,
  input  wire logic          i_shift_empty,
  input  wire logic          i_halt,
  input  wire logic          i_halt_gate_en,
  input  wire logic [1:0]    i_master_ctl
);
  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  uhe_host_req_t     hq;
  uhe_cpu_req_t      cq;
  uhe_rx_entry_t     rx_in;
  uhe_rx_entry_t     rx_head;
  logic [3:0]        ie_q;
  logic [7:0]        lcr_q;
  logic [4:0]        mcr_q;
  logic [7:0]        hold_q;
  logic              tx_full_q;
  logic              ovw_en_q;
  logic [ERR_W-1:0]  sh_err_q;
  logic [ERR_W-1:0]  lsr_err_q;
  logic              head_seen_q;
  logic              oe_q;
  logic              dr_q;
  logic              dr_sh_q;
  logic              holding_empty_flag_q;
  logic              holding_empty_flag_sh_q;
  logic              holding_empty_flag_prev_q;
  logic              holding_empty_flag_int_q;
  logic              temt_q;
  logic              tout_q;
  logic [3:0]        msr_hi_q;
  logic [3:0]        msr_prev_q;
  logic [3:0]        delta_q;
  logic [7:0]        iir_q;
  logic              dab;
  logic              h_rd_data;
  logic              h_wr_data;
  logic              h_rd_iir;
  logic              h_rd_lsr;
  logic              h_rd_msr;
  logic              h_wr_iir;
  logic              c_rd_hold;
  logic              c_wr_rx;
  logic              c_wr_lsr;
  logic              rx_ready;
  logic              rx_valid;
  logic              rx_full;
  logic              push;
  logic              ovw;
  logic              pop;
  logic              last_pop;
  logic [CNT_W-1:0]  rx_cnt;
  logic              err_stored;
  logic [ERR_W-1:0]  head_err;
  logic [ERR_W-1:0]  err_vis;
  logic              holding_empty_flag_host;
  logic [3:0]        msr_vis;
  logic              src_trig;
  logic [2:0]        iir_id;
  logic              iir_pend;
  logic [7:0]        lsr_host;
  logic [7:0]        lsr_cpu;

  // ---------------------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------------------
  // Synchronous request sampling
  // device clock ports
  assign hq  = i_host_req;
  assign cq  = i_cpu_req;
  assign dab = lcr_q[LCR_DAB];

  // Divisor access hides data and enable registers
  // divisor address switch
  assign h_rd_data = hq.rd && (hq.addr == HA_DATA) && !dab;
  assign h_wr_data = hq.wr && (hq.addr == HA_DATA) && !dab;
  assign h_rd_iir  = hq.rd && (hq.addr == HA_IIR);
  assign h_wr_iir  = hq.wr && (hq.addr == HA_IIR);
  assign h_rd_lsr  = hq.rd && (hq.addr == HA_LSR);
  assign h_rd_msr  = hq.rd && (hq.addr == HA_MSR);
  assign c_rd_hold = cq.rd && (cq.addr == CA_DATA);
  assign c_wr_rx   = cq.wr && (cq.addr == CA_DATA);
  assign c_wr_lsr  = cq.wr && (cq.addr == CA_LSR);

  // ---------------------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------------------
  // Overrun when buffer holds a byte (single) or FIFO is full
  // overrun detection
  assign rx_full = i_fifo_mode ? !rx_ready : (rx_cnt != '0);
  assign push    = c_wr_rx && !rx_full;
  assign ovw     = c_wr_rx && rx_full && ovw_en_q;
  assign pop     = h_rd_data && rx_valid;
  assign last_pop = pop && (rx_cnt == CNT_W'(1)) && !push;
  assign rx_in.err  = sh_err_q;
  assign rx_in.data = cq.wdata;

  uhe_fifo #(
    .WIDTH  (ENTRY_W),
    .DEPTH  (RX_DEPTH),
    .FLAG_L (DATA_W),
    .FLAG_W (ERR_W)
  ) u_rx_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_valid     (push),
    .o_ready     (rx_ready),
    .i_overwrite (ovw),
    .i_data      (rx_in),
    .o_valid     (rx_valid),
    .i_ready     (h_rd_data),
    .o_data      (rx_head),
    .o_count     (rx_cnt),
    .o_flag_any  (err_stored)
  );

  // Head byte flags shown until reported
  // head flags visible
  assign head_err = (rx_valid && !head_seen_q) ? rx_head.err : '0;
  assign err_vis  = lsr_err_q | head_err;

  // Error shadows, accumulated flags and overrun
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      sh_err_q    <= '0;
      lsr_err_q   <= '0;
      head_seen_q <= 1'b0;
      oe_q        <= 1'b0;
    end
    else
    begin
      if (c_wr_lsr)
        sh_err_q <= cq.wdata[LSR_ERR_L +: ERR_W];
      else if (c_wr_rx)
        sh_err_q <= '0;
      lsr_err_q <= (h_rd_lsr ? '0 : lsr_err_q) | (pop ? head_err : '0);
      if (pop)
        head_seen_q <= 1'b0;
      else if (h_rd_lsr && rx_valid)
        head_seen_q <= 1'b1;
      if (c_wr_rx && rx_full)
        oe_q <= 1'b1;
      else if (h_rd_lsr)
        oe_q <= 1'b0;
    end
  end

  // Data ready, host copy and undelayed shadow
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      dr_q    <= 1'b0;
      dr_sh_q <= 1'b0;
    end
    else
    begin
      if (((push || ovw) && !i_rx_delay_en) ||
          (i_rx_delay_done && rx_valid))
        dr_q <= 1'b1;
      else if (last_pop)
        dr_q <= 1'b0;
      if (push || ovw)
        dr_sh_q <= 1'b1;
      else if (last_pop)
        dr_sh_q <= 1'b0;
    end
  end

  // Receive timeout latch, dropped by a FIFO read
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      tout_q <= 1'b0;
    else if (i_rx_timeout && rx_valid)
      tout_q <= 1'b1;
    else if (pop)
      tout_q <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Transmit side
  // ---------------------------------------------------------------------------
  // Holding buffer and holding-empty copies
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      hold_q    <= BYTE_RST;
      tx_full_q <= 1'b0;
      holding_empty_flag_q    <= 1'b1;
      holding_empty_flag_sh_q <= 1'b1;
    end
    else
    begin
      if (h_wr_data)
        hold_q <= hq.wdata;
      if (h_wr_data)
        tx_full_q <= 1'b1;
      else if (c_rd_hold)
        tx_full_q <= 1'b0;
      if ((c_rd_hold && !i_tx_delay_en) || i_tx_delay_done)
        holding_empty_flag_q <= 1'b1;
      else if (h_wr_data)
        holding_empty_flag_q <= 1'b0;
      if (c_rd_hold)
        holding_empty_flag_sh_q <= 1'b1;
      else if (h_wr_data)
        holding_empty_flag_sh_q <= 1'b0;
    end
  end

  // Host copy hidden during halt
  // halt forcing
  assign holding_empty_flag_host = holding_empty_flag_q && !(i_halt && i_halt_gate_en);

  // Transmitter empty, processor written or automatic
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      temt_q <= 1'b0;
    else if (i_double_buf && holding_empty_flag_sh_q && !tx_full_q && i_shift_empty)
      temt_q <= 1'b1;
    else if (c_wr_lsr)
      temt_q <= cq.wdata[LSR_TEMT];
  end

  // Holding-empty interrupt source on rising host copy
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      holding_empty_flag_prev_q <= 1'b0;
      holding_empty_flag_int_q  <= 1'b0;
    end
    else
    begin
      holding_empty_flag_prev_q <= holding_empty_flag_host;
      if (holding_empty_flag_host && !holding_empty_flag_prev_q)
        holding_empty_flag_int_q <= 1'b1;
      else if (h_wr_iir || h_wr_data)
        holding_empty_flag_int_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Host written enables, line and modem control; processor tweaks
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ie_q     <= '0;
      lcr_q    <= BYTE_RST;
      mcr_q    <= '0;
      ovw_en_q <= 1'b0;
    end
    else
    begin
      if (hq.wr && (hq.addr == HA_IE) && !dab)
        ie_q <= hq.wdata[3:0];
      if (hq.wr && (hq.addr == HA_LCR))
        lcr_q <= hq.wdata;
      if (hq.wr && (hq.addr == HA_MCR))
        mcr_q <= hq.wdata[4:0];
      // only the defined bit is kept
      if (cq.wr && (cq.addr == CA_TWEAK))
        ovw_en_q <= cq.wdata[TWEAK_OVW];
    end
  end

  // ---------------------------------------------------------------------------
  // Modem status
  // ---------------------------------------------------------------------------
  // Loopback of modem outputs onto status inputs
  // loop mapping
  assign msr_vis = mcr_q[MCR_LOOP] ?
                   {mcr_q[MCR_OUT2], mcr_q[MCR_OUT1],
                    mcr_q[MCR_DTR], mcr_q[MCR_RTS]} : msr_hi_q;

  // Line state bits and delta detection
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      msr_hi_q   <= '0;
      msr_prev_q <= '0;
      delta_q    <= '0;
    end
    else
    begin
      if (cq.wr && (cq.addr == CA_MSR))
        msr_hi_q <= cq.wdata[7:4];
      msr_prev_q <= msr_vis;
      delta_q <= (h_rd_msr ? 4'h0 : delta_q) |
                 {msr_vis[3] ^ msr_prev_q[3],
                  msr_prev_q[2] & ~msr_vis[2],
                  msr_vis[1] ^ msr_prev_q[1],
                  msr_vis[0] ^ msr_prev_q[0]};
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt identification
  // ---------------------------------------------------------------------------
  // Trigger source drops once count falls below level
  // trigger level select
  assign src_trig = dr_q && (!i_fifo_mode || !rx_ready ||
                    (rx_cnt >= trig_level(i_trig_sel)));

  uhe_prio u_prio (
    .i_line  (ie_q[IE_LS] && (oe_q || (|err_vis))),
    .i_trig  (ie_q[IE_RDA] && src_trig),
    .i_tout  (ie_q[IE_RDA] && tout_q),
    .i_holding_empty_flag  (ie_q[IE_HOLDING_EMPTY_FLAG] && holding_empty_flag_int_q),
    .i_modem (ie_q[IE_MS] && (|delta_q)),
    .o_id    (iir_id),
    .o_pend  (iir_pend)
  );

  // Snapshot held while the host reads it
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      iir_q <= IIR_RST;
    else if (!h_rd_iir)
      iir_q <= {i_fifo_mode, i_fifo_mode, 2'b00, iir_id, ~iir_pend};
  end

  // Host interrupt pin, optionally gated by output 2
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_host_int <= 1'b0;
    else if (i_master_ctl == MASTER_OUT2)
      o_host_int <= iir_pend && mcr_q[MCR_OUT2];
    else
      o_host_int <= iir_pend;
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  // FIFO-error bit
  assign lsr_host = {i_fifo_mode && err_stored, temt_q, holding_empty_flag_host,
                     err_vis, oe_q, dr_q};
  assign lsr_cpu  = {i_fifo_mode && err_stored, temt_q, holding_empty_flag_sh_q,
                     err_vis, oe_q, dr_sh_q};

  // Host read mux, registered on the read strobe
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_host_rdata <= BYTE_RST;
    else if (hq.rd)
    begin
      case (hq.addr)
        HA_DATA: o_host_rdata <= (dab || !rx_valid) ? BYTE_RST : rx_head.data;
        HA_IE:   o_host_rdata <= dab ? BYTE_RST : {4'h0, ie_q};
        HA_IIR:  o_host_rdata <= iir_q;
        HA_LCR:  o_host_rdata <= lcr_q;
        HA_MCR:  o_host_rdata <= {3'b000, mcr_q};
        HA_LSR:  o_host_rdata <= lsr_host;
        HA_MSR:  o_host_rdata <= {msr_vis, delta_q};
        default: o_host_rdata <= BYTE_RST;
      endcase
    end
  end

  // Processor read mux and holding-full flag
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_cpu_rdata <= BYTE_RST;
      o_tx_full   <= 1'b0;
    end
    else
    begin
      o_tx_full <= tx_full_q;
      if (cq.rd)
      begin
        case (cq.addr)
          CA_DATA: o_cpu_rdata <= hold_q;
          CA_IE:   o_cpu_rdata <= {4'h0, ie_q};
          CA_LCR:  o_cpu_rdata <= lcr_q;
          CA_MCR:  o_cpu_rdata <= {3'b000, mcr_q};
          CA_LSR:  o_cpu_rdata <= lsr_cpu;
          CA_MSR:  o_cpu_rdata <= {msr_vis, delta_q};
          default: o_cpu_rdata <= BYTE_RST;
        endcase
      end
    end
  end

endmodule // uhe_host_regs

// File: bench/uhe_chk.sv
// Port checker of the host register block
`timescale 1ns/1ps
module uhe_chk
  import uhe_pkg::*;
(
  // Watched ports
  input wire logic              i_clk,
  input wire logic              i_rstn,
  input wire uhe_host_req_t     i_host_req,
  input wire logic              i_fifo_mode,
  input wire logic              i_halt,
  input wire logic              i_halt_gate_en,
  input wire logic [DATA_W-1:0] o_host_rdata
);
  // ----
  // Helpers
  // ----
  logic             dab_q;
  logic             hrd;
  logic [2:0]       ha;
  logic [DATA_W-1:0] rd;
  assign hrd = i_host_req.rd;
  assign ha  = i_host_req.addr;
  assign rd  = o_host_rdata;
  // Copy of the divisor access bit
  always_ff @(posedge i_clk)
    dab_q <= i_rstn && (i_host_req.wr && ha == HA_LCR ?
      i_host_req.wdata[LCR_DAB] : dab_q);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Host read relations
  iir_fixed_a: assert property (hrd && ha == HA_IIR |=>
    rd[5:4] == 2'b00 && rd[7:6] == {2{$past(i_fifo_mode, 2)}})
    else $error("iir fixed bits wrong");
  ie_upper_a: assert property (hrd && ha == HA_IE |=>
    rd[7:4] == 4'h0) else $error("enable upper bits set");
  mcr_upper_a: assert property (hrd && ha == HA_MCR |=>
    rd[7:5] == 3'h0) else $error("modem control upper bits set");
  dab_block_a: assert property (hrd && ha <= HA_IE && dab_q |=>
    rd == 8'h00) else $error("blocked register read through");
  fifo_err_a: assert property (hrd && ha == HA_LSR && !i_fifo_mode |=>
    !rd[7]) else $error("fifo error bit outside fifo mode");
  halt_holding_empty_flag_a: assert property (hrd && ha == HA_LSR && i_halt &&
    i_halt_gate_en |=> !rd[5]) else $error("holding empty not forced");
  lcr_echo_a: assert property (i_host_req.wr && ha == HA_LCR ##2
    hrd && ha == HA_LCR |=> rd == $past(i_host_req.wdata, 3))
    else $error("line control not stored");
  rdata_hold_a: assert property (!hrd |=> $stable(rd))
    else $error("host read data moved");
endmodule // uhe_chk

bind uhe_host_regs uhe_chk u_uhe_chk (.i_clk, .i_rstn, .i_host_req,
  .i_fifo_mode, .i_halt, .i_halt_gate_en, .o_host_rdata);

// File: bench/uhe_cpu_model.sv
// Processor core model on the processor register port
`timescale 1ns/1ps
module uhe_cpu_model
  import uhe_pkg::*;
(
  // Clock
  input  wire logic   i_clk,
  // Requests
  output uhe_cpu_req_t o_req
);
  // ----
  // Bus cycles
  // ----
  initial o_req = '0;
  // One access held across one edge
  task automatic acc(input logic r, input logic [7:0] a, d);
    @(negedge i_clk) o_req = '{r, !r, a, d};
    @(negedge i_clk) o_req = '0;
  endtask
  task automatic line(input logic [3:0] s);
    acc(1'b0, CA_MSR, {s, 4'h0});
  endtask
  task automatic tweak(input logic ovw);
    acc(1'b0, CA_TWEAK, {6'h00, ovw, 1'b0});
  endtask
endmodule // uhe_cpu_model

// File: bench/uhe_host_regs_bench.sv
// Self-checking bench of the host register block
`timescale 1ns/1ps
module uhe_host_regs_bench;
  import uhe_pkg::*;
  // ----
  // Signals
  // ----
  logic          i_clk;
  logic          i_rstn;
  logic          hint;
  logic          txf;
  logic [13:0]   md;
  logic [7:0]    hd;
  logic [7:0]    cd;
  uhe_host_req_t hq;
  uhe_cpu_req_t  cq;
  int            error_cnt = 0;
  int            comparisons = 0;
  uhe_cpu_model u_uhe_cpu_model (.i_clk, .o_req(cq));
  uhe_host_regs u_uhe_host_regs (.i_clk, .i_rstn, .i_host_req(hq),
    .o_host_rdata(hd), .o_host_int(hint), .i_cpu_req(cq), .o_cpu_rdata(cd),
    .o_tx_full(txf), .i_fifo_mode(md[0]), .i_trig_sel(md[2:1]),
    .i_rx_delay_en(md[3]), .i_rx_delay_done(md[4]), .i_tx_delay_en(md[5]),
    .i_tx_delay_done(md[6]), .i_rx_timeout(md[7]), .i_double_buf(md[8]),
    .i_shift_empty(md[9]), .i_halt(md[10]), .i_halt_gate_en(md[11]),
    .i_master_ctl(md[13:12]));
  // ----
  // Helpers
  // ----
  task automatic chk(input string n, input logic [7:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hx(input logic r, input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk) hq = '{r, !r, a, d};
    @(negedge i_clk) hq = '0;
  endtask
  task automatic hr(input logic [2:0] a, input logic [7:0] m, e);
    hx(1'b1, a, 8'h00);
    chk("host rdata", e, hd & m);
  endtask
  task automatic cx(input logic r, input logic [7:0] a, d);
    u_uhe_cpu_model.acc(r, a, d);
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_lcr;
    hx(1'b0, HA_LCR, 8'h9B);
    hr(HA_IE, 8'hFF, 8'h00);
    cx(1'b1, CA_LCR, 8'h00);
    chk("cpu rdata", 8'h9B, cd);
    hx(1'b0, HA_LCR, 8'h1B);
    hr(HA_LCR, 8'hFF, 8'h1B);
    hx(1'b0, HA_IE, 8'hF1);
    hr(HA_IE, 8'hFF, 8'h01);
  endtask
  task automatic t_tx;
    hx(1'b0, HA_DATA, 8'hC3);
    hr(HA_LSR, 8'h20, 8'h00);
    chk("tx full", 8'h01, {7'h00, txf});
    cx(1'b1, CA_DATA, 8'h00);
    chk("cpu rdata", 8'hC3, cd);
    hr(HA_LSR, 8'h20, 8'h20);
    chk("tx full", 8'h00, {7'h00, txf});
  endtask
  task automatic t_rx;
    md[11:10] = 2'b11;
    hr(HA_LSR, 8'h20, 8'h00);
    md[11:10] = 2'b00;
    cx(1'b0, CA_DATA, 8'h5A);
    hr(HA_LSR, 8'hA3, 8'h21);
    hr(HA_DATA, 8'hFF, 8'h5A);
    hr(HA_LSR, 8'h23, 8'h20);
    cx(1'b0, CA_LSR, 8'h04);
    cx(1'b0, CA_DATA, 8'h11);
    cx(1'b0, CA_DATA, 8'h22);
    hr(HA_LSR, 8'h3F, 8'h27);
    hr(HA_LSR, 8'h3F, 8'h21);
    hr(HA_DATA, 8'hFF, 8'h11);
    u_uhe_cpu_model.tweak(1'b1);
    cx(1'b0, CA_DATA, 8'h66);
    cx(1'b0, CA_DATA, 8'h77);
    hr(HA_DATA, 8'hFF, 8'h77);
    hr(HA_LSR, 8'h03, 8'h02);
    u_uhe_cpu_model.tweak(1'b0);
  endtask
  task automatic t_iir;
    hr(HA_IIR, 8'hFF, 8'h01);
    cx(1'b0, CA_DATA, 8'h44);
    repeat (3) @(negedge i_clk);
    chk("host int", 8'h01, {7'h00, hint});
    md[13:12] = 2'b10;
    repeat (2) @(negedge i_clk);
    chk("host int", 8'h00, {7'h00, hint});
    md[13:12] = 2'b00;
    hr(HA_IIR, 8'hFF, 8'h04);
    hr(HA_DATA, 8'hFF, 8'h44);
    repeat (3) @(negedge i_clk);
    hr(HA_IIR, 8'hFF, 8'h01);
    chk("host int", 8'h00, {7'h00, hint});
    md[0] = 1'b1;
    hr(HA_IIR, 8'hFF, 8'hC1);
    md[0] = 1'b0;
  endtask
  task automatic t_modem;
    u_uhe_cpu_model.line(4'h8);
    hr(HA_MSR, 8'hFF, 8'h88);
    u_uhe_cpu_model.line(4'h0);
    hr(HA_MSR, 8'hFF, 8'h08);
    hx(1'b0, HA_MCR, 8'hFF);
    hr(HA_MCR, 8'hFF, 8'h1F);
    hr(HA_MSR, 8'hFF, 8'hFB);
    hx(1'b0, HA_MCR, 8'h00);
    hr(HA_MSR, 8'hFF, 8'h0F);
  endtask
  // ----
  // Clock, sequence and watchdog
  // ----
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    {i_rstn, md, hq} = '0;
    repeat (2) @(negedge i_clk);
    i_rstn = 1'b1;
    t_lcr;
    t_tx;
    t_rx;
    t_iir;
    t_modem;
    conclude;
  end
  initial
  begin
    #20000;
    error_cnt++;
    conclude;
  end
endmodule // uhe_host_regs_bench
